// File: logic/mmd_decoder.sv
// memory map decoder with data flash ecc and program flash erase control
`timescale 1ns/1ps
`default_nettype none
// How it works
// RQ1: rom mode aliases boot rom over 64K
// RQ2: flash mode puts program flash at zero
// RQ3: 256-byte windows drive peripheral and system selects
// RQ4: reset starts with boot rom at zero
// RQ5: boot rom word index is 10 bits
// RQ6: program flash word index is 13 bits
// RQ7: page erase or mass erase of program flash
// RQ8: data flash word index is 9 bits
// RQ9: ram word index is 10 bits
// RQ10: six check bits stored per flash word
// RQ11: single-bit flash read errors are corrected
// RQ12: reset loads rom-mode boundaries
// RQ13: config access waits; privileged writes only
// RQ14: regions set by 1K low/high bounds
// RQ15: unused regions select nothing
// RQ16: privileged mode write switches the map
module mmd_decoder
	import mmd_pkg::*;
#(
	parameter int ECC_DATA_W = DATA_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire mmd_req_s busReq,
	input wire mmd_erase_s eraseIn,
	input wire logic dfRdValid,
	input wire logic [CW_W-1:0] dfRdRaw,
	output logic [NREG-1:0] memSel_r,
	output logic [9:0] periphSel_r,
	output logic [2:0] sysSel_r,
	output logic [WADDR_W-1:0] wordAddr_r,
	output logic busWait_r,
	output logic [DATA_W-1:0] cfgRdata_r,
	output logic dfWe_r,
	output logic [CW_W-1:0] dfWdata_r,
	output logic [DATA_W-1:0] dfRdata_r,
	output logic dfCorr_r,
	output mmd_erase_s eraseOut_r,
	output logic mapMode_r
);
	if (ECC_DATA_W != DATA_W) begin : g_chk
		$error("ecc is built for 32-bit words only");
	end

	// check bit k covers every hamming position with bit k set
	function automatic logic [CHK_W-1:0] eccCheck(input logic [DATA_W-1:0] d);
		logic [CHK_W-1:0] c;
		int j;
		c = '0;
		j = 0;
		for (int p = 1; p <= CW_W; p++) begin
			if ((p & (p - 1)) != 0) begin
				for (int k = 0; k < CHK_W; k++) begin
					if (p[k]) begin
						c[k] = c[k] ^ d[j];
					end
				end
				j++;
			end
		end
		return c;
	endfunction

	function automatic logic [DATA_W-1:0] eccFix(input logic [CW_W-1:0] w);
		logic [DATA_W-1:0] d;
		logic [CHK_W-1:0] syn;
		int j;
		d = w[DATA_W-1:0];
		syn = eccCheck(d) ^ w[CW_W-1:DATA_W];
		j = 0;
		for (int p = 1; p <= CW_W; p++) begin
			if ((p & (p - 1)) != 0) begin
				if (syn == CHK_W'(p)) begin
					d[j] = ~d[j];
				end
				j++;
			end
		end
		return d;
	endfunction

	logic [BLK_W-1:0] lo_r [NREG];
	logic [BLK_W-1:0] hi_r [NREG];
	logic cfgTouched_r;
	logic [NREG-1:0] hit;
	logic [NREG-1:0] memSel_nxt;
	logic [9:0] periphSel_nxt;
	logic [2:0] sysSel_nxt;
	logic [WADDR_W-1:0] wordAddr_nxt;
	logic [DATA_W-1:0] cfgRd;
	logic [BLK_W-1:0] blk;
	logic [31:0] a;
	logic take;
	logic cfgAcc;
	logic cfgWr;
	logic [2:0] bndIdx;

	assign a = busReq.addr;
	// a request during the wait cycle is dropped, the master must retry
	assign take = busReq.valid && !busWait_r;
	assign blk = a[BLK_LSB+BLK_W-1:BLK_LSB];
	assign cfgAcc = take && (a[31:8] == CFG_WIN); // RQ13
	assign cfgWr = cfgAcc && busReq.write && busReq.priv; // RQ13
	assign bndIdx = 3'((a[7:0] - CFG_BND_OFS) >> 2);

	// region hits; lowest index wins on overlap
	for (genvar i = 0; i < NREG; i++) begin : g_hit
		assign hit[i] = (a[31:BLK_LSB+BLK_W] == '0) && (blk >= lo_r[i]) && (blk <= hi_r[i]); // RQ14
	end

	always_comb begin
		memSel_nxt = '0;
		wordAddr_nxt = '0;
		for (int i = NREG - 1; i >= 0; i--) begin
			if (hit[i]) begin
				memSel_nxt = '0;
				memSel_nxt[i] = 1'b1;
				// offset from the region base; the mask folds rom copies together
				wordAddr_nxt = WADDR_W'((a - {8'h00, lo_r[i], 10'h000}) >> 2)
					& WMASK[i]; // RQ1 RQ5 RQ6 RQ8 RQ9
			end
		end
	end

	always_comb begin
		periphSel_nxt = '0;
		sysSel_nxt = '0;
		case (a[31:8]) // RQ3
			24'hFFF7D8: periphSel_nxt[9] = 1'b1;
			24'hFFF7DC: periphSel_nxt[8] = 1'b1;
			24'hFFF7E0, 24'hFFF7E1: periphSel_nxt[7] = 1'b1;
			24'hFFF7E4, 24'hFFF7E5: periphSel_nxt[6] = 1'b1;
			24'hFFF7E8, 24'hFFF7E9: periphSel_nxt[5] = 1'b1;
			24'hFFF7EC, 24'hFFF7ED: periphSel_nxt[4] = 1'b1;
			24'hFFF7F0: periphSel_nxt[3] = 1'b1;
			24'hFFF7F6: periphSel_nxt[2] = 1'b1;
			24'hFFF7F8, 24'hFFF7FA: periphSel_nxt[1] = 1'b1;
			24'hFFF7FD: periphSel_nxt[0] = 1'b1;
			24'hFFFFFD: sysSel_nxt[2] = 1'b1;
			24'hFFFFFE: sysSel_nxt[1] = 1'b1;
			24'hFFFFFF: begin
				sysSel_nxt[0] = (a[7:0] >= 8'h20 && a[7:0] <= 8'h37)
					|| (a[7:0] >= 8'h40 && a[7:0] <= 8'h50)
					|| (a[7:0] >= 8'hD0 && a[7:0] <= 8'hEC);
			end
			default: begin
				sysSel_nxt = '0; // RQ15
			end
		endcase
	end

	always_comb begin
		cfgRd = '0;
		if (a[7:0] == CFG_MODE_OFS) begin
			cfgRd = DATA_W'(mapMode_r);
		end else if (a[7:0] >= CFG_BND_OFS && a[7:0] < 8'h30) begin
			cfgRd = DATA_W'(a[2] ? hi_r[bndIdx[2:1]] : lo_r[bndIdx[2:1]]);
		end
	end

	// selects are registered; nothing is selected without a taken request
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			memSel_r <= '0;
			periphSel_r <= '0;
			sysSel_r <= '0;
			wordAddr_r <= '0;
		end else begin
			memSel_r <= take ? memSel_nxt : '0; // RQ15
			periphSel_r <= take ? periphSel_nxt : '0;
			sysSel_r <= take ? sysSel_nxt : '0;
			wordAddr_r <= take ? wordAddr_nxt : '0;
		end
	end

	// boundaries: reset to rom map, a mode write reloads the mode's preset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mapMode_r <= MAP_ROM; // RQ4 RQ12
			cfgTouched_r <= 1'b0;
			for (int i = 0; i < NREG; i++) begin
				lo_r[i] <= ROM_LO[i];
				hi_r[i] <= ROM_HI[i];
			end
		end else if (cfgWr && a[7:0] == CFG_MODE_OFS) begin
			mapMode_r <= busReq.wdata[0]; // RQ16
			cfgTouched_r <= 1'b0;
			for (int i = 0; i < NREG; i++) begin
				lo_r[i] <= busReq.wdata[0] ? FL_LO[i] : ROM_LO[i]; // RQ1 RQ2
				hi_r[i] <= busReq.wdata[0] ? FL_HI[i] : ROM_HI[i];
			end
		end else if (cfgWr && a[7:0] >= CFG_BND_OFS && a[7:0] < 8'h30) begin
			cfgTouched_r <= 1'b1;
			if (a[2]) begin
				hi_r[bndIdx[2:1]] <= busReq.wdata[BLK_W-1:0]; // RQ14
			end else begin
				lo_r[bndIdx[2:1]] <= busReq.wdata[BLK_W-1:0];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busWait_r <= 1'b0;
			cfgRdata_r <= '0;
		end else begin
			busWait_r <= cfgAcc; // RQ13
			if (cfgAcc && !busReq.write) begin
				cfgRdata_r <= cfgRd;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dfWe_r <= 1'b0;
			dfWdata_r <= '0;
		end else begin
			dfWe_r <= take && busReq.write && memSel_nxt[2];
			if (take && busReq.write && memSel_nxt[2]) begin
				dfWdata_r <= {eccCheck(busReq.wdata), busReq.wdata}; // RQ10
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dfRdata_r <= '0;
			dfCorr_r <= 1'b0;
		end else begin
			dfCorr_r <= dfRdValid && (eccCheck(dfRdRaw[DATA_W-1:0]) != dfRdRaw[CW_W-1:DATA_W]);
			if (dfRdValid) begin
				dfRdata_r <= eccFix(dfRdRaw); // RQ11
			end
		end
	end

	// erase carries no privilege check in this design, so any request is passed on
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			eraseOut_r <= '0;
		end else begin
			eraseOut_r.req <= eraseIn.req; // RQ7
			eraseOut_r.mass <= eraseIn.req && eraseIn.mass;
			eraseOut_r.page <= eraseIn.req && !eraseIn.mass ? eraseIn.page : '0;
		end
	end

	selOnehot_a: assert property (@(posedge clk) disable iff (!rst_n)
		$onehot0({memSel_r, periphSel_r, sysSel_r}))
		else $error("more than one select active"); // RQ15
	romAlias_a: assert property (@(posedge clk) disable iff (!rst_n)
		take && mapMode_r == MAP_ROM && !cfgTouched_r && a[31:16] == 16'h0000
		|=> memSel_r == 4'h1 && wordAddr_r == 13'($past(a[11:2])))
		else $error("boot rom alias missing"); // RQ1
	flashLow_a: assert property (@(posedge clk) disable iff (!rst_n)
		take && mapMode_r == MAP_FLASH && !cfgTouched_r && a[31:15] == '0
		|=> memSel_r == 4'h2)
		else $error("program flash not at zero"); // RQ2
	flashGap_a: assert property (@(posedge clk) disable iff (!rst_n)
		take && mapMode_r == MAP_FLASH && !cfgTouched_r && a >= 32'h0000B000 && a < 32'h00018800
		|=> memSel_r == '0)
		else $error("select in unused gap"); // RQ2
	loopShare_a: assert property (@(posedge clk) disable iff (!rst_n)
		take && (a[31:8] == 24'hFFF7E1 || a[31:8] == 24'hFFF7E0) |=> periphSel_r == 10'h080)
		else $error("loop 4 windows not shared"); // RQ3
	cfgWait_a: assert property (@(posedge clk) disable iff (!rst_n)
		cfgAcc |=> busWait_r ##1 !busWait_r)
		else $error("config wait not one cycle"); // RQ13
	userWrite_a: assert property (@(posedge clk) disable iff (!rst_n)
		cfgAcc && busReq.write && !busReq.priv |=> $stable(mapMode_r) && $stable(lo_r[0]))
		else $error("user write changed config"); // RQ13
	eccStore_a: assert property (@(posedge clk) disable iff (!rst_n)
		dfWe_r |-> dfWdata_r[CW_W-1:DATA_W] == eccCheck(dfWdata_r[DATA_W-1:0])
			&& dfWdata_r[DATA_W-1:0] == $past(busReq.wdata))
		else $error("check bits wrong"); // RQ10
	eccFix_a: assert property (@(posedge clk) disable iff (!rst_n)
		dfRdValid && eccCheck(dfRdRaw[DATA_W-1:0]) == dfRdRaw[CW_W-1:DATA_W]
		|=> dfRdata_r == $past(dfRdRaw[DATA_W-1:0]) && !dfCorr_r)
		else $error("clean word altered"); // RQ11
	eraseMass_a: assert property (@(posedge clk) disable iff (!rst_n)
		eraseIn.req && eraseIn.mass |=> eraseOut_r.req && eraseOut_r.mass && eraseOut_r.page == '0)
		else $error("mass erase malformed"); // RQ7
endmodule
`default_nettype wire

// File: logic/mmd_pkg.sv
// package: address map, boundary defaults, ecc sizes and carriers of the memory map decoder
`default_nettype none
package mmd_pkg;
	localparam int DATA_W = 32;
	localparam int CHK_W = 6;
	localparam int CW_W = DATA_W + CHK_W;
	localparam int BLK_W = 14;
	localparam int BLK_LSB = 10;
	localparam int NREG = 4;
	localparam int WADDR_W = 13;
	localparam int ROM_WORDS = 1024;
	localparam int PFL_WORDS = 8192;
	localparam int DFL_WORDS = 512;
	localparam int RAM_WORDS = 1024;
	localparam int PAGE_W = 5;
	localparam logic [23:0] CFG_WIN = 24'hFFFFFE;
	localparam logic [7:0] CFG_MODE_OFS = 8'h00;
	localparam logic [7:0] CFG_BND_OFS = 8'h10;
	localparam logic [BLK_W-1:0] ROM_LO [NREG] = '{14'h0000, 14'h0040, 14'h0062, 14'h0064};
	localparam logic [BLK_W-1:0] ROM_HI [NREG] = '{14'h003F, 14'h005F, 14'h0063, 14'h0067};
	localparam logic [BLK_W-1:0] FL_LO [NREG] = '{14'h0028, 14'h0000, 14'h0062, 14'h0064};
	localparam logic [BLK_W-1:0] FL_HI [NREG] = '{14'h002B, 14'h001F, 14'h0063, 14'h0067};
	localparam logic [WADDR_W-1:0] WMASK [NREG] = '{13'h03FF, 13'h1FFF, 13'h01FF, 13'h03FF};
	typedef enum logic [0:0] {
		MAP_ROM = 1'b0,
		MAP_FLASH = 1'b1
	} mmd_map_e;
	typedef struct packed {
		logic valid;
		logic write;
		logic priv;
		logic [31:0] addr;
		logic [DATA_W-1:0] wdata;
	} mmd_req_s;
	typedef struct packed {
		logic req;
		logic mass;
		logic [PAGE_W-1:0] page;
	} mmd_erase_s;
endpackage
`default_nettype wire

// File: dv/mmd_flash_model.sv
// data flash array partner: keeps written codewords, returns one on request
`timescale 1ns/1ps
`default_nettype none
module mmd_flash_model
	import mmd_pkg::*;
(
	input wire logic clk,
	input wire logic we,
	input wire logic [CW_W-1:0] wdata,
	input wire logic [WADDR_W-1:0] widx,
	input wire logic rdGo,
	input wire logic [8:0] rdIdx,
	input wire logic [5:0] flip,
	output logic rdValid,
	output logic [CW_W-1:0] rdRaw
);
	logic [CW_W-1:0] store [DFL_WORDS];
	initial rdRaw = '0;
	initial rdValid = 1'b0;
	always @(posedge clk) begin
		if (we) begin
			store[widx[8:0]] <= wdata;
		end
		rdValid <= rdGo;
		// idle data inverts so a stale word never passes for a fresh one
		rdRaw <= rdGo ? store[rdIdx] ^ (CW_W'(1) << flip) : ~rdRaw;
	end
endmodule
`default_nettype wire

// File: dv/tb.sv
// bench: address map, selects, config access, ecc and erase pass-through
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checksDone++; if ((g) !== (e)) begin errTotal++; \
	$display("BAD %s exp %0h got %0h", n, e, g); end end
module tb;
	import mmd_pkg::*;
	localparam logic [31:0] CFG = 32'hFFFFFE00;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	mmd_req_s busReq = '0;
	mmd_erase_s eraseIn = '0;
	logic rdGo = 1'b0;
	logic [8:0] rdIdx = '0;
	logic [5:0] flip = '0;
	logic dfRdValid, dfWe_r, dfCorr_r, busWait_r, mapMode_r;
	logic [CW_W-1:0] dfRdRaw, dfWdata_r;
	logic [NREG-1:0] memSel_r;
	logic [9:0] periphSel_r;
	logic [2:0] sysSel_r;
	logic [WADDR_W-1:0] wordAddr_r;
	logic [DATA_W-1:0] cfgRdata_r, dfRdata_r;
	mmd_erase_s eraseOut_r;
	int errTotal = 0;
	int checksDone = 0;
	always #5 clk = ~clk;
	mmd_decoder DUT(.clk(clk), .rst_n(rst_n), .busReq(busReq), .eraseIn(eraseIn),
		.dfRdValid(dfRdValid), .dfRdRaw(dfRdRaw), .memSel_r(memSel_r),
		.periphSel_r(periphSel_r), .sysSel_r(sysSel_r), .wordAddr_r(wordAddr_r),
		.busWait_r(busWait_r), .cfgRdata_r(cfgRdata_r), .dfWe_r(dfWe_r),
		.dfWdata_r(dfWdata_r), .dfRdata_r(dfRdata_r), .dfCorr_r(dfCorr_r),
		.eraseOut_r(eraseOut_r), .mapMode_r(mapMode_r));
	mmd_flash_model flash(.clk(clk), .we(dfWe_r), .wdata(dfWdata_r), .widx(wordAddr_r),
		.rdGo(rdGo), .rdIdx(rdIdx), .flip(flip), .rdValid(dfRdValid), .rdRaw(dfRdRaw));
	task automatic give_verdict;
		$display("checks %0d errors %0d", checksDone, errTotal);
		if (errTotal == 0 && checksDone > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// one request, held to the taking edge; outputs sampled while they stand
	task automatic req(input logic [31:0] a, input logic wr, input logic pr, input logic [31:0] d);
		@(posedge clk);
		busReq <= '{1'b1, wr, pr, a, d};
		@(posedge clk);
		busReq.valid <= 1'b0;
		#1;
	endtask
	// ps is {system selects, peripheral selects}
	task automatic pb(input logic [31:0] a, input logic [3:0] m, input logic [12:0] ps,
		input logic [12:0] w);
		req(a, 1'b0, 1'b0, '0);
		`CHK("memSel", m, memSel_r)
		`CHK("sel", ps, {sysSel_r, periphSel_r})
		`CHK("wordAddr", w, wordAddr_r)
	endtask
	task automatic t_rommap;
		pb(32'h00000000, 4'h1, 13'h0, 13'h0);
		pb(32'h0000F004, 4'h1, 13'h0, 13'h1);
		pb(32'h00017FFC, 4'h2, 13'h0, 13'h1FFF);
		pb(32'h00018000, 4'h0, 13'h0, 13'h0);
		pb(32'h00018FFC, 4'h4, 13'h0, 13'h1FF);
		pb(32'h00019FFC, 4'h8, 13'h0, 13'h3FF);
		pb(32'h0001A000, 4'h0, 13'h0, 13'h0);
	endtask
	task automatic t_periph;
		pb(32'hFFF7D800, 4'h0, 13'h0200, 13'h0);
		pb(32'hFFF7DC00, 4'h0, 13'h0100, 13'h0);
		pb(32'hFFF7E1FC, 4'h0, 13'h0080, 13'h0);
		pb(32'hFFF7E400, 4'h0, 13'h0040, 13'h0);
		pb(32'hFFF7E9FC, 4'h0, 13'h0020, 13'h0);
		pb(32'hFFF7EC00, 4'h0, 13'h0010, 13'h0);
		pb(32'hFFF7F000, 4'h0, 13'h0008, 13'h0);
		pb(32'hFFF7F6FC, 4'h0, 13'h0004, 13'h0);
		pb(32'hFFF7FA00, 4'h0, 13'h0002, 13'h0);
		pb(32'hFFF7FD00, 4'h0, 13'h0001, 13'h0);
		pb(32'hFFFFFD00, 4'h0, 13'h1000, 13'h0);
		pb(32'hFFFFFF50, 4'h0, 13'h0400, 13'h0);
		pb(32'hFFFFFFEC, 4'h0, 13'h0400, 13'h0);
		pb(32'hFFF7D900, 4'h0, 13'h0, 13'h0);
	endtask
	task automatic t_cfg;
		req(CFG, 1'b1, 1'b0, 32'h1);
		`CHK("wait", 1'b1, busWait_r)
		`CHK("sysSel", 3'h2, sysSel_r)
		`CHK("userWrite", 1'b0, mapMode_r)
		@(posedge clk);
		busReq <= '{1'b1, 1'b1, 1'b1, CFG, 32'h1};
		@(posedge clk);
		busReq <= '{1'b1, 1'b0, 1'b0, 32'h00019000, 32'h0};
		@(posedge clk);
		busReq.valid <= 1'b0;
		#1;
		`CHK("duringWait", 4'h0, memSel_r)
		`CHK("mode", 1'b1, mapMode_r)
		pb(32'h00000000, 4'h2, 13'h0, 13'h0);
		pb(32'h00007FFC, 4'h2, 13'h0, 13'h1FFF);
		pb(32'h00008000, 4'h0, 13'h0, 13'h0);
		pb(32'h0000A004, 4'h1, 13'h0, 13'h1);
		pb(32'h0000B000, 4'h0, 13'h0, 13'h0);
		pb(32'h00019000, 4'h8, 13'h0, 13'h0);
		req(CFG, 1'b0, 1'b0, 32'h0);
		`CHK("cfgRead", 32'h1, cfgRdata_r)
		req(CFG + 32'h2C, 1'b1, 1'b1, 32'h68);
		req(CFG + 32'h2C, 1'b0, 1'b0, 32'h0);
		`CHK("bndRead", 32'h68, cfgRdata_r)
		pb(32'h0001A000, 4'h8, 13'h0, 13'h0);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		`CHK("resetMode", 1'b0, mapMode_r)
		@(posedge clk);
		rst_n <= 1'b1;
		pb(32'h00000000, 4'h1, 13'h0, 13'h0);
	endtask
	task automatic t_ecc;
		logic [31:0] d;
		d = 32'hA5C31E69;
		req(32'h00018804, 1'b1, 1'b0, d);
		`CHK("dfWe", 1'b1, dfWe_r)
		`CHK("dfWdata", d, dfWdata_r[31:0])
		`CHK("dfIdx", 13'h1, wordAddr_r)
		for (int f = 0; f <= CW_W; f++) begin
			@(posedge clk);
			rdIdx <= 9'h1;
			flip <= 6'(f);
			rdGo <= 1'b1;
			@(posedge clk);
			rdGo <= 1'b0;
			@(posedge clk);
			#1;
			`CHK("dfRdata", d, dfRdata_r)
			`CHK("dfCorr", f < CW_W, dfCorr_r)
		end
	endtask
	task automatic t_erase;
		@(posedge clk);
		eraseIn <= '{1'b1, 1'b0, 5'h1F};
		@(posedge clk);
		eraseIn <= '{1'b1, 1'b1, 5'h07};
		#1;
		`CHK("page", 7'h5F, eraseOut_r)
		@(posedge clk);
		eraseIn <= '0;
		#1;
		`CHK("mass", 7'h60, eraseOut_r)
	endtask
	initial begin
		repeat (2) @(posedge clk);
		#1;
		`CHK("resetSel", 4'h0, memSel_r)
		@(posedge clk);
		rst_n <= 1'b1;
		t_rommap();
		t_periph();
		t_cfg();
		t_ecc();
		t_erase();
		give_verdict();
	end
	// whole run is well under 2000 cycles
	initial begin
		#50000;
		errTotal++;
		give_verdict();
	end
endmodule
`default_nettype wire
